// File: shared/tmc_defs.svh
// register offsets, field positions, reset values and timing counts for the timer core
// assumes a 32-bit classic wishbone slave, word aligned registers
`ifndef TMC_DEFS_SVH
`define TMC_DEFS_SVH
`define TMC_OFS_CTRL     8'h00
`define TMC_OFS_CNT_LO   8'h04
`define TMC_OFS_CNT_HI   8'h08
`define TMC_OFS_CMPA_LO  8'h0C
`define TMC_OFS_CMPA_HI  8'h10
`define TMC_OFS_CMPB_LO  8'h14
`define TMC_OFS_CMPB_HI  8'h18
`define TMC_OFS_CMPP_LO  8'h1C
`define TMC_OFS_CMPP_HI  8'h20
`define TMC_OFS_PINSEL0  8'h24
`define TMC_OFS_PINSEL1  8'h28
`define TMC_OFS_PORTINV  8'h2C
`define TMC_OFS_IRQ_STAT 8'h30
`define TMC_OFS_IRQ_MASK 8'h34
`define TMC_OFS_ID       8'h38
// control register fields
`define TMC_CTRL_RUN      0
`define TMC_CTRL_CKSEL_LO 1
`define TMC_CTRL_EDGE     4
`define TMC_CTRL_MODE_LO  5
`define TMC_CTRL_ACT_LO   6
`define TMC_CTRL_CLRSRC   8
// clock select codes
`define TMC_CK_SYS4     3'h0
`define TMC_CK_SYS      3'h1
`define TMC_CK_HIGH16   3'h2
`define TMC_CK_HIGH64   3'h3
`define TMC_CK_TBC      3'h4
`define TMC_CK_RSVD     3'h5
`define TMC_CK_EXT_RISE 3'h6
`define TMC_CK_EXT_ALT  3'h7
// divider ratios
`define TMC_DIV_SYS4    8'h03
`define TMC_DIV_HIGH16  8'h0F
`define TMC_DIV_HIGH64  8'h3F
// reset values of pin select registers and the identity value
`define TMC_PINSEL0_RST 8'h93
`define TMC_PINSEL1_RST 8'h11
`define TMC_ID_VALUE    32'h0000_5A11
`endif

// File: shared/tmc_pkg.sv
// types shared by the timer core
// assumes tmc_defs.svh for numeric constants
package tmc_pkg;
    typedef enum logic [1:0] {
        TMC_ACT_NONE,
        TMC_ACT_LOW,
        TMC_ACT_HIGH,
        TMC_ACT_TOGGLE
    } tmc_act_type;
    typedef enum logic [1:0] {
        TMC_MODE_CMP,
        TMC_MODE_PWM
    } tmc_mode_type;
    typedef struct packed {
        logic [2:0] cksel;
        logic       edge_fall;
        logic       pwm;
        tmc_act_type act;
        logic       clr_on_a;
        logic       run;
    } tmc_ctrl_type;
    typedef struct packed {
        logic hit_p;
        logic hit_b;
        logic hit_a;
    } tmc_irq_type;
endpackage : tmc_pkg

// File: rtl/tmc_core.sv
// timer module common core: 16-bit counter, comparators a, b, p, pin routing
// assumes a classic wishbone master on mclk; pins external to mclk domain
//
// Chosen here: register access over Wishbone and the register addresses.
`timescale 1ns/1ns
`include "tmc_defs.svh"
module tmc_core
    import tmc_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        high_clk_tick,
    input  wire logic        tbc_tick,
    input  wire logic        ext_clk_pin,
    output logic [7:0]       timer_out_pin,
    output logic [7:0]       timer_out_en,
    output logic             irq
);
    logic [7:0]   pinsel0_r, pinsel1_r, portinv_r;
    logic [9:0]   ctrl_r;
    tmc_ctrl_type ctl;
    logic [15:0]  cnt_r, cmpa_r, cmpb_r, cmpp_r;
    logic [7:0]   buf_wr_r, buf_rd_r;
    logic [2:0]   stat_r, mask_r;
    logic         ext_s1_r, ext_s2_r, ext_s3_r;
    logic [7:0]   div_r;
    logic         out_r;
    logic         tick, ext_edge, acc, wr, rd;
    tmc_irq_type  hit;
    logic         hit_a_clr;

    assign ctl = {ctrl_r[3:1], ctrl_r[4], ctrl_r[5], tmc_act_type'(ctrl_r[7:6]), ctrl_r[8], ctrl_r[0]};

    // byte-lane write helper, only lane 0 carries the 8-bit fields
    function automatic logic [7:0] lane0(input logic [7:0] old, input logic [3:0] sel, input logic [31:0] d);
        lane0 = sel[0] ? d[7:0] : old;
    endfunction : lane0

    // wishbone handshake: one wait state, ack drops after one cycle
    assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr  = acc && wb_we_i;
    assign rd  = acc && !wb_we_i;
    always_ff @(posedge mclk) begin
        if (!resetn) wb_ack_o <= 1'b0;
        else         wb_ack_o <= acc;
    end

    // pin synchroniser, the edge detector reads only stages two and three
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
            ext_s3_r <= 1'b0;
        end else begin
            ext_s1_r <= ext_clk_pin && pinsel0_r[0];
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
        end
    end
    assign ext_edge = ctl.edge_fall ? (ext_s3_r && !ext_s2_r) : (!ext_s3_r && ext_s2_r);

    // prescaler for the divided clock choices
    always_ff @(posedge mclk) begin
        if (!resetn) div_r <= 8'h00;
        else         div_r <= div_r + 8'h01;
    end

    // clock source select; reserved code feeds nothing
    always_comb begin
        case (ctl.cksel)
            `TMC_CK_SYS4:     tick = (div_r & `TMC_DIV_SYS4) == `TMC_DIV_SYS4;
            `TMC_CK_SYS:      tick = 1'b1;
            `TMC_CK_HIGH16:   tick = high_clk_tick && ((div_r & `TMC_DIV_HIGH16) == `TMC_DIV_HIGH16);
            `TMC_CK_HIGH64:   tick = high_clk_tick && ((div_r & `TMC_DIV_HIGH64) == `TMC_DIV_HIGH64);
            `TMC_CK_TBC:      tick = tbc_tick;
            `TMC_CK_RSVD:     tick = 1'b0;
            default:          tick = ext_edge;
        endcase
        tick = tick && ctl.run;
    end

    // comparator hits, sampled on the counter value
    assign hit.hit_a = tick && (cnt_r == cmpa_r);
    assign hit.hit_b = tick && (cnt_r == cmpb_r);
    assign hit.hit_p = tick && (cnt_r == cmpp_r);
    assign hit_a_clr = ctl.clr_on_a ? hit.hit_a : hit.hit_p;

    // counter: wraps naturally, clear on selected match, buffered write via high byte
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            cnt_r <= 16'h0000;
        end else if (wr && wb_adr_i == `TMC_OFS_CNT_HI) begin
            cnt_r <= {lane0(cnt_r[15:8], wb_sel_i, wb_dat_i), buf_wr_r};
        end else if (hit_a_clr) begin
            cnt_r <= 16'h0000;
        end else if (tick) begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end

    // low-byte write buffer and read latch shared by all pairs
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            buf_wr_r <= 8'h00;
            buf_rd_r <= 8'h00;
        end else begin
            if (wr && (wb_adr_i == `TMC_OFS_CNT_LO || wb_adr_i == `TMC_OFS_CMPA_LO ||
                       wb_adr_i == `TMC_OFS_CMPB_LO || wb_adr_i == `TMC_OFS_CMPP_LO))
                buf_wr_r <= lane0(buf_wr_r, wb_sel_i, wb_dat_i);
            if (rd) begin
                if      (wb_adr_i == `TMC_OFS_CNT_HI)  buf_rd_r <= cnt_r[7:0];
                else if (wb_adr_i == `TMC_OFS_CMPA_HI) buf_rd_r <= cmpa_r[7:0];
                else if (wb_adr_i == `TMC_OFS_CMPB_HI) buf_rd_r <= cmpb_r[7:0];
                else if (wb_adr_i == `TMC_OFS_CMPP_HI) buf_rd_r <= cmpp_r[7:0];
            end
        end
    end

    // comparator registers, loaded only on the high-byte write
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            cmpa_r <= 16'hFFFF;
            cmpb_r <= 16'hFFFF;
            cmpp_r <= 16'hFFFF;
        end else if (wr) begin
            if (wb_adr_i == `TMC_OFS_CMPA_HI) cmpa_r <= {lane0(cmpa_r[15:8], wb_sel_i, wb_dat_i), buf_wr_r};
            if (wb_adr_i == `TMC_OFS_CMPB_HI) cmpb_r <= {lane0(cmpb_r[15:8], wb_sel_i, wb_dat_i), buf_wr_r};
            if (wb_adr_i == `TMC_OFS_CMPP_HI) cmpp_r <= {lane0(cmpp_r[15:8], wb_sel_i, wb_dat_i), buf_wr_r};
        end
    end

    // plain configuration registers
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            ctrl_r    <= 10'h000;
            pinsel0_r <= `TMC_PINSEL0_RST;
            pinsel1_r <= `TMC_PINSEL1_RST;
            portinv_r <= 8'h00;
            mask_r    <= 3'h0;
        end else if (wr) begin
            if (wb_adr_i == `TMC_OFS_CTRL) begin
                if (wb_sel_i[0]) ctrl_r[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1]) ctrl_r[9:8] <= wb_dat_i[9:8];
            end
            else if (wb_adr_i == `TMC_OFS_PINSEL0)  pinsel0_r <= lane0(pinsel0_r, wb_sel_i, wb_dat_i);
            else if (wb_adr_i == `TMC_OFS_PINSEL1)  pinsel1_r <= lane0(pinsel1_r, wb_sel_i, wb_dat_i);
            else if (wb_adr_i == `TMC_OFS_PORTINV)  portinv_r <= lane0(portinv_r, wb_sel_i, wb_dat_i);
            else if (wb_adr_i == `TMC_OFS_IRQ_MASK && wb_sel_i[0]) mask_r <= wb_dat_i[2:0];
        end
    end

    // sticky status: a hit in the clearing cycle wins over the write-one clear
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            stat_r <= 3'h0;
        end else begin
            stat_r <= (stat_r & ~((wr && wb_adr_i == `TMC_OFS_IRQ_STAT && wb_sel_i[0]) ? wb_dat_i[2:0] : 3'h0))
                      | {hit.hit_p, hit.hit_b, hit.hit_a};
        end
    end
    assign irq = |(stat_r & mask_r);

    // output state: match actions in compare mode, set at p and clear at a in pwm mode
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            out_r <= 1'b0;
        end else if (ctl.pwm) begin
            if (hit.hit_a)      out_r <= 1'b0;
            else if (hit.hit_p) out_r <= 1'b1;
        end else if (hit.hit_a) begin
            case (ctl.act)
                TMC_ACT_LOW:    out_r <= 1'b0;
                TMC_ACT_HIGH:   out_r <= 1'b1;
                TMC_ACT_TOGGLE: out_r <= !out_r;
                default:        out_r <= out_r;
            endcase
        end
    end

    // pins: enable from select bits, per-pin inversion gives complementary pairs
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            timer_out_pin <= 8'h00;
            timer_out_en  <= 8'h00;
        end else begin
            timer_out_pin <= {8{out_r}} ^ portinv_r;
            timer_out_en  <= {pinsel1_r[5:4], pinsel1_r[1:0], pinsel0_r[7:4]};
        end
    end

    // read mux; low bytes return the latch filled by the high-byte read
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (rd) begin
            if      (wb_adr_i == `TMC_OFS_CTRL)     wb_dat_o <= {22'h0, ctrl_r};
            else if (wb_adr_i == `TMC_OFS_CNT_HI)   wb_dat_o <= {24'h0, cnt_r[15:8]};
            else if (wb_adr_i == `TMC_OFS_CMPA_HI)  wb_dat_o <= {24'h0, cmpa_r[15:8]};
            else if (wb_adr_i == `TMC_OFS_CMPB_HI)  wb_dat_o <= {24'h0, cmpb_r[15:8]};
            else if (wb_adr_i == `TMC_OFS_CMPP_HI)  wb_dat_o <= {24'h0, cmpp_r[15:8]};
            else if (wb_adr_i == `TMC_OFS_CNT_LO || wb_adr_i == `TMC_OFS_CMPA_LO ||
                     wb_adr_i == `TMC_OFS_CMPB_LO || wb_adr_i == `TMC_OFS_CMPP_LO)
                wb_dat_o <= {24'h0, buf_rd_r};
            else if (wb_adr_i == `TMC_OFS_PINSEL0)  wb_dat_o <= {24'h0, pinsel0_r};
            else if (wb_adr_i == `TMC_OFS_PINSEL1)  wb_dat_o <= {24'h0, pinsel1_r};
            else if (wb_adr_i == `TMC_OFS_PORTINV)  wb_dat_o <= {24'h0, portinv_r};
            else if (wb_adr_i == `TMC_OFS_IRQ_STAT) wb_dat_o <= {29'h0, stat_r};
            else if (wb_adr_i == `TMC_OFS_IRQ_MASK) wb_dat_o <= {29'h0, mask_r};
            else if (wb_adr_i == `TMC_OFS_ID)       wb_dat_o <= `TMC_ID_VALUE; // value is arbitrary
            else                                    wb_dat_o <= 32'h0000_0000;
        end
    end

    // checks
    reserved_stop_a: assert property (@(posedge mclk) disable iff (!resetn)
        (ctl.cksel == `TMC_CK_RSVD) && !(wr && wb_adr_i == `TMC_OFS_CNT_HI) |=> $stable(cnt_r))
        else $error("counter moved on reserved clock");
    sys_count_a: assert property (@(posedge mclk) disable iff (!resetn)
        ctl.run && ctl.cksel == `TMC_CK_SYS && !hit_a_clr && !wr |=> cnt_r == $past(cnt_r) + 16'h0001)
        else $error("counter did not advance");
    match_irq_a: assert property (@(posedge mclk) disable iff (!resetn)
        hit.hit_a |=> stat_r[0])
        else $error("match a not flagged");
    match_p_a: assert property (@(posedge mclk) disable iff (!resetn)
        hit.hit_p |=> stat_r[2])
        else $error("match p not flagged");
    match_b_a: assert property (@(posedge mclk) disable iff (!resetn)
        hit.hit_b |=> stat_r[1])
        else $error("match b not flagged");
    clear_on_a: assert property (@(posedge mclk) disable iff (!resetn)
        hit_a_clr && !wr |=> cnt_r == 16'h0000)
        else $error("counter not cleared");
    toggle_out_a: assert property (@(posedge mclk) disable iff (!resetn)
        !ctl.pwm && ctl.act == TMC_ACT_TOGGLE && hit.hit_a |=> out_r != $past(out_r))
        else $error("output not toggled");
    invert_pin_a: assert property (@(posedge mclk) disable iff (!resetn)
        ##1 timer_out_pin == ({8{$past(out_r)}} ^ $past(portinv_r)))
        else $error("inversion wrong");
    ext_only_a: assert property (@(posedge mclk) disable iff (!resetn)
        ctl.cksel == `TMC_CK_EXT_RISE && ctl.run && !ext_edge && !wr |=> $stable(cnt_r))
        else $error("counted without edge");
    cover_match_a: cover property (@(posedge mclk) hit.hit_a);
    cover_pwm:     cover property (@(posedge mclk) ctl.pwm && hit.hit_p ##[1:50] hit.hit_a);
    cover_ext:     cover property (@(posedge mclk) ext_edge && tick);
endmodule : tmc_core

// File: tb/tmc_pins_model.sv
// partner model: outside circuitry on the shared timer pins
// assumes the bench calls its tasks from a process that runs on mclk
`timescale 1ns/1ns
module tmc_pins_model (
    input  wire logic       mclk,
    input  wire logic [7:0] timer_out_pin,
    input  wire logic [7:0] timer_out_en,
    output logic            ext_clk_pin,
    output logic [7:0]      pad_level
);
    // undriven pads float to the pull-up level, so a missing enable shows as a high
    assign pad_level = (timer_out_pin & timer_out_en) | ~timer_out_en;
    // external clock idles low between bursts
    initial ext_clk_pin = 1'b0;
    // slow edges leave the three-stage synchroniser room to settle
    task automatic edge_to(input logic lvl);
        repeat (4) @(posedge mclk);
        ext_clk_pin <= lvl;
    endtask : edge_to
    // n whole pulses, each with one rising and one falling edge
    task automatic pulses(input int n);
        for (int i = 0; i < n; i++) begin
            edge_to(1'b1);
            edge_to(1'b0);
        end
        repeat (6) @(posedge mclk);
    endtask : pulses
endmodule : tmc_pins_model

// File: tb/timer_module_common_core_bench.sv
// self-checking bench for the timer core: registers, counting, matches, pins
// assumes the core's wishbone slave answers well within 40 cycles
`timescale 1ns/1ns
`include "tmc_defs.svh"
module timer_module_common_core_bench;
    logic        mclk, resetn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
    logic        high_clk_tick, tbc_tick, ext_clk_pin, pre, fall;
    logic [7:0]  wb_adr_i, timer_out_pin, timer_out_en, pad_level;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rdat;
    logic [15:0] cnt, start;
    int          compares, miscompares, k;

    tmc_core tmc_core_inst (.mclk(mclk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .high_clk_tick(high_clk_tick), .tbc_tick(tbc_tick),
        .ext_clk_pin(ext_clk_pin), .timer_out_pin(timer_out_pin), .timer_out_en(timer_out_en), .irq(irq));
    tmc_pins_model tmc_pins_model_inst (.mclk(mclk), .timer_out_pin(timer_out_pin),
        .timer_out_en(timer_out_en), .ext_clk_pin(ext_clk_pin), .pad_level(pad_level));

    // 25 MHz clock
    always #20 mclk = ~mclk;
    // derived clock enables wander at random so those paths see traffic
    always @(posedge mclk) begin
        high_clk_tick <= 1'($urandom);
        tbc_tick      <= 1'($urandom);
    end

    task automatic conclude();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    // one classic cycle; held until ack is sampled, then one idle cycle
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        // reads ignore the byte lanes, so they get random lanes to show it
        wb_sel_i <= we ? 4'hF : 4'($urandom);
        wb_dat_i <= wd;
        do begin
            @(posedge mclk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 40);
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge mclk);
        if (n >= 40) begin
            miscompares++;
            conclude();
        end
    endtask : xfer

    task automatic wr(input logic [7:0] adr, input logic [31:0] d);
        xfer(1'b1, adr, d);
    endtask : wr

    task automatic rdc(input logic [7:0] adr, input logic [31:0] exp);
        xfer(1'b0, adr, 32'h0000_0000);
        check(rdat, exp);
    endtask : rdc

    // low byte goes to the buffer first, the high byte write moves both
    task automatic set16(input logic [7:0] lo, input logic [15:0] v);
        wr(lo, {24'h0, v[7:0]});
        wr(lo + 8'h04, {24'h0, v[15:8]});
    endtask : set16

    // high byte read latches the low byte, so the pair is coherent
    task automatic get_cnt();
        xfer(1'b0, `TMC_OFS_CNT_HI, 32'h0000_0000);
        cnt[15:8] = rdat[7:0];
        xfer(1'b0, `TMC_OFS_CNT_LO, 32'h0000_0000);
        cnt[7:0] = rdat[7:0];
    endtask : get_cnt

    function automatic logic [31:0] ctrl_w(input logic [2:0] ck, input logic fe, input logic pw,
                                           input logic [1:0] act);
        return {23'h0, 1'b0, act, pw, fe, ck, 1'b1};
    endfunction : ctrl_w

    // pin level after an a match: 1 low, 2 high, 3 toggle, 4 pwm clears at a
    function automatic logic exp_raw(input int m, input logic p);
        return (m == 2) ? 1'b1 : ((m == 3) ? ~p : 1'b0);
    endfunction : exp_raw

    initial begin
        void'($urandom(18));
        {mclk, resetn, wb_cyc_i, wb_stb_i, wb_we_i, high_clk_tick, tbc_tick} = '0;
        {wb_adr_i, wb_sel_i, wb_dat_i, compares, miscompares} = '0;
        repeat (6) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        // reset values, identity, unmapped place, read-write access
        check(irq, 1'b0);
        rdc(`TMC_OFS_PINSEL0, 32'h0000_0093);
        rdc(`TMC_OFS_PINSEL1, 32'h0000_0011);
        rdc(`TMC_OFS_ID, `TMC_ID_VALUE);
        rdc(8'h3C, 32'h0000_0000);
        wr(`TMC_OFS_PINSEL1, 32'h0000_0033);
        rdc(`TMC_OFS_PINSEL1, 32'h0000_0033);
        $display("test registers done");
        // stopped code ignores pin pulses; system clock counts about once per cycle
        wr(`TMC_OFS_CTRL, ctrl_w(`TMC_CK_RSVD, 1'b0, 1'b0, 2'd0));
        set16(`TMC_OFS_CNT_LO, 16'h1234);
        tmc_pins_model_inst.pulses(3);
        get_cnt();
        check(cnt, 16'h1234);
        set16(`TMC_OFS_CNT_LO, 16'h0000);
        wr(`TMC_OFS_CTRL, ctrl_w(`TMC_CK_SYS, 1'b0, 1'b0, 2'd0));
        repeat (100) @(posedge mclk);
        wr(`TMC_OFS_CTRL, ctrl_w(`TMC_CK_RSVD, 1'b0, 1'b0, 2'd0));
        get_cnt();
        check(cnt >= 16'd100 && cnt <= 16'd112, 1'b1);
        $display("test clock select done");
        // random bursts on the external pin, both edges, wrap from all ones
        for (int i = 0; i < 6; i++) begin
            start = (i == 0) ? 16'hFFFF : 16'($urandom);
            k     = 1 + $urandom % 12;
            fall  = i[0];
            wr(`TMC_OFS_CTRL, ctrl_w(`TMC_CK_RSVD, 1'b0, 1'b0, 2'd0));
            set16(`TMC_OFS_CNT_LO, start);
            wr(`TMC_OFS_CTRL, ctrl_w(fall ? `TMC_CK_EXT_ALT : `TMC_CK_EXT_RISE, fall, 1'b0, 2'd0));
            tmc_pins_model_inst.pulses(k);
            get_cnt();
            check(cnt, 16'(start + k));
            tmc_pins_model_inst.edge_to(1'b1);
            repeat (6) @(posedge mclk);
            get_cnt();
            check(cnt, 16'(start + k + !fall));
            tmc_pins_model_inst.edge_to(1'b0);
            repeat (6) @(posedge mclk);
            get_cnt();
            check(cnt, 16'(start + k + 1));
        end
        $display("test external clock done");
        // b at 2, a at 3, p at 5, counted on the external pin
        set16(`TMC_OFS_CMPB_LO, 16'h0002);
        set16(`TMC_OFS_CMPA_LO, 16'h0003);
        set16(`TMC_OFS_CMPP_LO, 16'h0005);
        for (int m = 1; m <= 4; m++) begin
            wr(`TMC_OFS_CTRL, ctrl_w(`TMC_CK_RSVD, 1'b0, 1'b0, 2'd0));
            set16(`TMC_OFS_CNT_LO, 16'h0000);
            wr(`TMC_OFS_IRQ_STAT, 32'h0000_0007);
            wr(`TMC_OFS_PINSEL0, 32'h0000_0001);
            check(timer_out_en[3:0], 4'h0);
            wr(`TMC_OFS_PINSEL0, 32'h0000_00F1);
            check(timer_out_en[3:0], 4'hF);
            wr(`TMC_OFS_PORTINV, m[0] ? 32'h0000_00FF : 32'h0000_0000);
            pre = pad_level[0] ^ m[0];
            wr(`TMC_OFS_CTRL, ctrl_w(`TMC_CK_EXT_RISE, 1'b0, m == 4, 2'(m)));
            // a match is flagged by the tick taken while the count equals the comparator
            tmc_pins_model_inst.pulses(3);
            rdc(`TMC_OFS_IRQ_STAT, 32'h0000_0002);
            tmc_pins_model_inst.pulses(1);
            rdc(`TMC_OFS_IRQ_STAT, 32'h0000_0003);
            check(pad_level[3:0], {4{exp_raw(m, pre) ^ m[0]}});
            tmc_pins_model_inst.pulses(2);
            rdc(`TMC_OFS_IRQ_STAT, 32'h0000_0007);
            if (m == 4) begin
                check(pad_level[0], 1'b1 ^ m[0]);
            end
            wr(`TMC_OFS_IRQ_MASK, 32'h0000_0001);
            check(irq, 1'b1);
            wr(`TMC_OFS_IRQ_STAT, 32'h0000_0001);
            rdc(`TMC_OFS_IRQ_STAT, 32'h0000_0006);
            check(irq, 1'b0);
        end
        $display("test compare match done");
        conclude();
    end
endmodule : timer_module_common_core_bench
